// [clkguard_pkg.sv]
// constants, register map and carrier types for the clock guard block
// assumes an 8-bit register port and one core clock at 10 MHz
package clkguard_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] OFS_WRITE_PROTECT = 4'h0;
	localparam logic [3:0] OFS_PROC_MODE2 = 4'h1;
	localparam logic [3:0] OFS_CLOCK_CTRL0 = 4'h2;
	localparam logic [3:0] OFS_CLOCK_CTRL1 = 4'h3;
	localparam logic [3:0] OFS_CLOCK_CTRL2 = 4'h4;
	localparam logic [3:0] OFS_PLL_CTRL = 4'h5;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int B_PROT_CLOCK = 0;
	localparam int B_PROT_MODE = 1;
	localparam int B_PROT_PORT = 2;
	localparam int B_PROT_VOLT = 3;
	localparam int B_CLOCK_LOCK = 1;
	localparam int B_PERIPH_STOP_IN_WAIT = 2;
	localparam int B_SUB_OSC_ON = 4;
	localparam int B_MAIN_OSC_STOP = 5;
	localparam int B_DIV8_SELECT = 6;
	localparam int B_SUB_CLOCK_SELECT = 7;
	localparam int B_ALL_CLOCKS_OFF = 0;
	localparam int B_PLL_CPU_SELECT = 1;
	localparam int B_DIV_SEL_LO = 6;
	localparam int B_DIV_SEL_HI = 7;
	localparam int B_OSC_DETECT_ENABLE = 0;
	localparam int B_RING_OSC_SELECT = 1;
	localparam int B_STOP_DETECTED = 2;
	localparam int B_MAIN_STOPPED = 3;
	localparam int B_DETECT_ACTION = 7;
	localparam int B_PLL_ON = 7;

	// ----------------------------------------------------------------
	// reset values and write masks under the clock lock
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CLOCK_CTRL0 = 8'h40;
	localparam logic [7:0] RST_CLOCK_CTRL1 = 8'h00;
	localparam logic [7:0] RST_CLOCK_CTRL2 = 8'h00;
	localparam logic [7:0] RST_PLL_CTRL = 8'h00;
	localparam logic [7:0] RST_PROC_MODE2 = 8'h00;
	localparam logic [3:0] RST_WRITE_PROTECT = 4'h0;
	localparam logic [7:0] LOCK_MASK_CTRL0 = 8'hA4;
	localparam logic [7:0] LOCK_MASK_CTRL1 = 8'h03;
	localparam logic [7:0] LOCK_MASK_CTRL2 = 8'h01;
	localparam logic [7:0] LOCK_MASK_PLL = 8'hFF;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		SRC_MAIN = 4'b0001,
		SRC_PLL = 4'b0010,
		SRC_RING = 4'b0100,
		SRC_SUB = 4'b1000
	} clk_src_e;

	typedef enum logic [2:0] {
		PWR_RUN = 3'b001,
		PWR_WAIT = 3'b010,
		PWR_STOP = 3'b100
	} pwr_mode_e;

	typedef struct packed {
		clk_src_e cpu_src;
		clk_src_e periph_src;
		logic [4:0] cpu_div;
	} clk_sel_s;

	typedef struct packed {
		logic main_en;
		logic sub_en;
		logic ring_en;
		logic pll_en;
	} osc_en_s;

endpackage

// [clock_guard.sv]
// clock guard: divider and source select, power modes, clock lock,
// oscillation stop and re-oscillation detection, register protection
// assumes register strobes and EXT_WRITE come from logic on CORE_CLK;
// MAIN_OSC_RUNNING comes from the oscillator and is synchronised here
//
// Contract
// R01: div8 set divides by eight, else 00/01/10/11 give 1,2,4,16.
// R02: sub-clock-select 1 picks sub clock; 0 picks main, PLL or ring.
// R03: sub-clock-oscillate bit 0 stops sub oscillator, 1 runs it.
// R04: main-clock-stop bit 0 keeps main oscillating, 1 stops it.
// R05: ring-select 1 makes ring oscillator the CPU source.
// R06: all-clocks-off write enters stop; wait instruction enters wait.
// R07: clock lock blocks writes to listed clock bits and PLL register.
// R08: software sets lock only on running, selected main clock.
// R09: software never executes wait while the lock is set.
// R10: detect enable arms detection; action bit picks reset or irq.
// R11: detection needs main clock above 2 MHz, else keep disabled.
// R12: reset action on main stop halts device until hardware reset.
// R13: stop on main source: irq, ring takes over, flags set.
// R14: stop on PLL source: irq and flags set, ring select unchanged.
// R15: restart: irq, stop-detected 1, main-stopped 0, ring unchanged.
// R16: detect irq shares vector; stop-detected flag tells sources apart.
// R17: stop-detected flag blocks further detect irqs until cleared.
// R18: stop in low-speed mode: CPU stays on sub, peripherals on ring.
// R19: software disables detection before stop mode or main stop change.
// R20: protect register gates clock, mode, port and voltage groups.
// R21: port-group protect bit clears after the next write anywhere.
// R22: clock, mode and voltage protect bits clear only by software.
// R23: blocked writes leave stored values unchanged, without error.
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps

module clock_guard
	import clkguard_pkg::*;
(
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RESETN,
	// register port
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	// system events
	input wire logic EXT_WRITE,
	input wire logic WAIT_EXEC,
	input wire logic HW_INTERRUPT,
	input wire logic MAIN_OSC_RUNNING,
	// clock control outputs
	output clk_sel_s CLK_SEL,
	output osc_en_s OSC_EN,
	output pwr_mode_e PWR_MODE,
	output logic PERIPH_STOP_IN_WAIT,
	// detection outputs
	output logic DETECT_IRQ,
	output logic OSC_STOP_RESET,
	// write gates for registers kept elsewhere
	output logic PORT_GROUP_WE,
	output logic VOLTAGE_GROUP_WE
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] merge(input logic [7:0] old_v,
		input logic [7:0] new_v, input logic [7:0] keep);
		merge = (old_v & keep) | (new_v & ~keep);
	endfunction

	function automatic logic [4:0] div_ratio(input logic d8,
		input logic hi, input logic lo);
		if (d8) begin
			div_ratio = 5'h08;
		end else begin
			case ({hi, lo})
				2'b00: div_ratio = 5'h01;
				2'b01: div_ratio = 5'h02;
				2'b10: div_ratio = 5'h04;
				default: div_ratio = 5'h10;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// registers and decode
	// ----------------------------------------------------------------
	logic [3:0] write_protect_reg;
	logic [7:0] proc_mode2_reg;
	logic [7:0] clock_ctrl0_reg;
	logic [7:0] clock_ctrl1_reg;
	logic [7:0] clock_ctrl2_reg;
	logic [7:0] pll_ctrl_reg;
	logic periph_ring_fallback;
	logic main_sync1;
	logic main_sync2;
	logic main_prev;
	pwr_mode_e pwr_state;
	pwr_mode_e next_pwr_state;

	logic clock_lock;
	logic clk_wr_ok;
	logic wr_ctrl0;
	logic wr_ctrl1;
	logic wr_ctrl2;
	logic wr_pll;
	logic wr_pm2;
	logic [7:0] keep0;
	logic [7:0] keep1;
	logic [7:0] keep2;
	logic [7:0] keep_pll;
	logic main_fell;
	logic main_rose;
	logic detect_on;
	logic irq_action;
	logic irq_event;
	logic stop_event;
	logic enter_stop;

	assign clock_lock = proc_mode2_reg[B_CLOCK_LOCK];
	assign clk_wr_ok = write_protect_reg[B_PROT_CLOCK]; // R20
	assign wr_ctrl0 = WR && ADDR == OFS_CLOCK_CTRL0 && clk_wr_ok; // R23
	assign wr_ctrl1 = WR && ADDR == OFS_CLOCK_CTRL1 && clk_wr_ok;
	assign wr_ctrl2 = WR && ADDR == OFS_CLOCK_CTRL2 && clk_wr_ok;
	assign wr_pll = WR && ADDR == OFS_PLL_CTRL && clk_wr_ok;
	assign wr_pm2 = WR && ADDR == OFS_PROC_MODE2 &&
		write_protect_reg[B_PROT_MODE]; // R20
	assign keep0 = clock_lock ? LOCK_MASK_CTRL0 : 8'h00; // R07
	assign keep1 = clock_lock ? LOCK_MASK_CTRL1 : 8'h00; // R07
	assign keep2 = clock_lock ? LOCK_MASK_CTRL2 : 8'h00; // R07
	assign keep_pll = clock_lock ? LOCK_MASK_PLL : 8'h00; // R07
	assign enter_stop = wr_ctrl1 && !keep1[B_ALL_CLOCKS_OFF] &&
		WDATA[B_ALL_CLOCKS_OFF]; // R06

	// ----------------------------------------------------------------
	// main oscillator sense and detection events
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			main_sync1 <= 1'b1;
			main_sync2 <= 1'b1;
			main_prev <= 1'b1;
		end else begin
			main_sync1 <= MAIN_OSC_RUNNING;
			main_sync2 <= main_sync1;
			main_prev <= main_sync2;
		end
	end

	assign main_fell = main_prev && !main_sync2;
	assign main_rose = !main_prev && main_sync2;
	assign detect_on = clock_ctrl2_reg[B_OSC_DETECT_ENABLE]; // R10
	assign irq_action = clock_ctrl2_reg[B_DETECT_ACTION]; // R10
	assign stop_event = detect_on && main_fell;
	// flag still set blocks a further request
	assign irq_event = detect_on && irq_action && (main_fell || main_rose)
		&& !clock_ctrl2_reg[B_STOP_DETECTED]; // R17

	// ----------------------------------------------------------------
	// protect register
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			write_protect_reg <= RST_WRITE_PROTECT;
		end else if (WR && ADDR == OFS_WRITE_PROTECT) begin
			write_protect_reg <= WDATA[3:0]; // R22
		end else if (WR || EXT_WRITE) begin
			write_protect_reg[B_PROT_PORT] <= 1'b0; // R21
		end
	end

	// ----------------------------------------------------------------
	// processor mode 2 (clock lock)
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			proc_mode2_reg <= RST_PROC_MODE2;
		end else if (wr_pm2) begin
			proc_mode2_reg <= WDATA;
		end
	end

	// ----------------------------------------------------------------
	// clock control 0 and 1
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			clock_ctrl0_reg <= RST_CLOCK_CTRL0;
		end else begin
			if (wr_ctrl0) begin
				clock_ctrl0_reg <= merge(clock_ctrl0_reg, WDATA, keep0);
			end
			if (enter_stop) begin
				clock_ctrl0_reg[B_DIV8_SELECT] <= 1'b1;
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			clock_ctrl1_reg <= RST_CLOCK_CTRL1;
		end else if (pwr_state == PWR_STOP && HW_INTERRUPT) begin
			clock_ctrl1_reg[B_ALL_CLOCKS_OFF] <= 1'b0; // R06
		end else if (wr_ctrl1) begin
			clock_ctrl1_reg <= merge(clock_ctrl1_reg, WDATA, keep1);
		end
	end

	// ----------------------------------------------------------------
	// clock control 2: hardware updates win over software writes
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			clock_ctrl2_reg <= RST_CLOCK_CTRL2;
		end else begin
			if (wr_ctrl2) begin
				clock_ctrl2_reg <= merge(clock_ctrl2_reg, WDATA, keep2);
			end
			if (irq_event) begin
				clock_ctrl2_reg[B_STOP_DETECTED] <= 1'b1; // R17
				clock_ctrl2_reg[B_MAIN_STOPPED] <= main_fell; // R15
			end
			if (irq_event && main_fell &&
				CLK_SEL.cpu_src == SRC_MAIN) begin
				clock_ctrl2_reg[B_RING_OSC_SELECT] <= 1'b1; // R13
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			pll_ctrl_reg <= RST_PLL_CTRL;
		end else if (wr_pll) begin
			pll_ctrl_reg <= merge(pll_ctrl_reg, WDATA, keep_pll);
		end
	end

	// peripherals move to ring when main stops under sub clock
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			periph_ring_fallback <= 1'b0;
		end else if (irq_event && main_fell &&
			CLK_SEL.cpu_src == SRC_SUB) begin
			periph_ring_fallback <= 1'b1; // R18
		end else if (wr_ctrl2 && !WDATA[B_MAIN_STOPPED]) begin
			periph_ring_fallback <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// detection outputs
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			DETECT_IRQ <= 1'b0;
		end else begin
			DETECT_IRQ <= irq_event; // R13 R14 R15 R16
		end
	end

	// held until the external hardware reset
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			OSC_STOP_RESET <= 1'b0;
		end else if (stop_event && !irq_action) begin
			OSC_STOP_RESET <= 1'b1; // R12
		end
	end

	// ----------------------------------------------------------------
	// power mode machine
	// ----------------------------------------------------------------
	always_comb begin
		next_pwr_state = pwr_state;
		case (pwr_state)
			PWR_RUN: begin
				if (enter_stop) begin
					next_pwr_state = PWR_STOP; // R06
				end else if (WAIT_EXEC) begin
					next_pwr_state = PWR_WAIT; // R06
				end
			end
			PWR_WAIT, PWR_STOP: begin
				if (HW_INTERRUPT) begin
					next_pwr_state = PWR_RUN; // R06
				end
			end
			default: next_pwr_state = PWR_RUN;
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			pwr_state <= PWR_RUN;
		end else begin
			pwr_state <= next_pwr_state;
		end
	end

	// ----------------------------------------------------------------
	// clock selection and oscillator enables
	// ----------------------------------------------------------------
	always_comb begin
		if (clock_ctrl0_reg[B_SUB_CLOCK_SELECT]) begin
			CLK_SEL.cpu_src = SRC_SUB; // R02
		end else if (clock_ctrl2_reg[B_RING_OSC_SELECT]) begin
			CLK_SEL.cpu_src = SRC_RING; // R05
		end else if (clock_ctrl1_reg[B_PLL_CPU_SELECT]) begin
			CLK_SEL.cpu_src = SRC_PLL;
		end else begin
			CLK_SEL.cpu_src = SRC_MAIN;
		end
		if (clock_ctrl2_reg[B_RING_OSC_SELECT] || periph_ring_fallback) begin
			CLK_SEL.periph_src = SRC_RING; // R13 R18
		end else begin
			CLK_SEL.periph_src = SRC_MAIN;
		end
		CLK_SEL.cpu_div = div_ratio(clock_ctrl0_reg[B_DIV8_SELECT],
			clock_ctrl1_reg[B_DIV_SEL_HI],
			clock_ctrl1_reg[B_DIV_SEL_LO]); // R01
	end

	assign OSC_EN.main_en = !clock_ctrl0_reg[B_MAIN_OSC_STOP] &&
		pwr_state != PWR_STOP; // R04
	assign OSC_EN.sub_en = clock_ctrl0_reg[B_SUB_OSC_ON] &&
		pwr_state != PWR_STOP; // R03
	assign OSC_EN.ring_en = (clock_ctrl2_reg[B_RING_OSC_SELECT] ||
		periph_ring_fallback) && pwr_state != PWR_STOP;
	assign OSC_EN.pll_en = pll_ctrl_reg[B_PLL_ON] && pwr_state != PWR_STOP;
	assign PWR_MODE = pwr_state;
	assign PERIPH_STOP_IN_WAIT = clock_ctrl0_reg[B_PERIPH_STOP_IN_WAIT];
	assign PORT_GROUP_WE = write_protect_reg[B_PROT_PORT]; // R20
	assign VOLTAGE_GROUP_WE = write_protect_reg[B_PROT_VOLT]; // R20

	// ----------------------------------------------------------------
	// read port, data one cycle after the strobe
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			RDATA <= 8'h00;
		end else if (RD) begin
			case (ADDR)
				OFS_WRITE_PROTECT: RDATA <= {4'h0, write_protect_reg};
				OFS_PROC_MODE2: RDATA <= proc_mode2_reg;
				OFS_CLOCK_CTRL0: RDATA <= clock_ctrl0_reg;
				OFS_CLOCK_CTRL1: RDATA <= clock_ctrl1_reg;
				OFS_CLOCK_CTRL2: RDATA <= clock_ctrl2_reg; // R16
				OFS_PLL_CTRL: RDATA <= pll_ctrl_reg;
				default: RDATA <= 8'h00;
			endcase
		end else begin
			RDATA <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_div8;
		@(posedge CORE_CLK) disable iff (!RESETN)
		clock_ctrl0_reg[B_DIV8_SELECT] |-> CLK_SEL.cpu_div == 5'h08;
	endproperty
	a_div8: assert property (p_div8) // R01
		else $error("div8 not giving eight");

	property p_lock_pll;
		@(posedge CORE_CLK) disable iff (!RESETN)
		(clock_lock && WR && ADDR == OFS_PLL_CTRL) |=>
			$stable(pll_ctrl_reg);
	endproperty
	a_lock_pll: assert property (p_lock_pll) // R07
		else $error("pll control changed under lock");

	property p_stop_entry;
		@(posedge CORE_CLK) disable iff (!RESETN)
		enter_stop |=> pwr_state == PWR_STOP &&
			clock_ctrl0_reg[B_DIV8_SELECT];
	endproperty
	a_stop_entry: assert property (p_stop_entry) // R06
		else $error("stop mode not entered");

	property p_reset_hold;
		@(posedge CORE_CLK) disable iff (!RESETN)
		$rose(OSC_STOP_RESET) |=> OSC_STOP_RESET [*8];
	endproperty
	a_reset_hold: assert property (p_reset_hold) // R12
		else $error("stop reset released early");

	property p_ring_take;
		@(posedge CORE_CLK) disable iff (!RESETN)
		(irq_event && main_fell && CLK_SEL.cpu_src == SRC_MAIN) |=>
			DETECT_IRQ && CLK_SEL.cpu_src == SRC_RING &&
			clock_ctrl2_reg[B_MAIN_STOPPED];
	endproperty
	a_ring_take: assert property (p_ring_take) // R13
		else $error("ring fallback missing");

	property p_pll_ring_kept;
		@(posedge CORE_CLK) disable iff (!RESETN)
		(irq_event && CLK_SEL.cpu_src == SRC_PLL && !wr_ctrl2) |=>
			!clock_ctrl2_reg[B_RING_OSC_SELECT];
	endproperty
	a_pll_ring_kept: assert property (p_pll_ring_kept) // R14
		else $error("ring select moved on pll source");

	property p_blocked;
		@(posedge CORE_CLK) disable iff (!RESETN)
		clock_ctrl2_reg[B_STOP_DETECTED] |=> !DETECT_IRQ;
	endproperty
	a_blocked: assert property (p_blocked) // R17
		else $error("detect irq while flag set");

	property p_port_clear;
		@(posedge CORE_CLK) disable iff (!RESETN)
		(write_protect_reg[B_PROT_PORT] && EXT_WRITE && !WR) |=>
			!PORT_GROUP_WE;
	endproperty
	a_port_clear: assert property (p_port_clear) // R21
		else $error("port protect not cleared");

	property p_clock_kept;
		@(posedge CORE_CLK) disable iff (!RESETN)
		(write_protect_reg[B_PROT_CLOCK] && EXT_WRITE &&
			!(WR && ADDR == OFS_WRITE_PROTECT)) |=>
			write_protect_reg[B_PROT_CLOCK];
	endproperty
	a_clock_kept: assert property (p_clock_kept) // R22
		else $error("clock protect cleared by hardware");

	property p_unprot;
		@(posedge CORE_CLK) disable iff (!RESETN)
		(WR && ADDR == OFS_CLOCK_CTRL1 && !clk_wr_ok &&
			!(pwr_state == PWR_STOP && HW_INTERRUPT)) |=>
			$stable(clock_ctrl1_reg);
	endproperty
	a_unprot: assert property (p_unprot) // R23
		else $error("protected write landed");

endmodule

// [test_clock_guard.sv]
// self-checking testbench for the clock guard block
// assumes clkguard_pkg and clock_guard are compiled first; one 10 MHz clock
`timescale 1ns/100ps

module test_clock_guard
	import clkguard_pkg::*;
;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic CORE_CLK;
	logic RESETN;
	logic [3:0] ADDR;
	logic [7:0] WDATA;
	logic WR;
	logic RD;
	logic [7:0] RDATA;
	logic EXT_WRITE;
	logic WAIT_EXEC;
	logic HW_INTERRUPT;
	logic MAIN_OSC_RUNNING;
	clk_sel_s CLK_SEL;
	osc_en_s OSC_EN;
	pwr_mode_e PWR_MODE;
	logic PERIPH_STOP_IN_WAIT;
	logic DETECT_IRQ;
	logic OSC_STOP_RESET;
	logic PORT_GROUP_WE;
	logic VOLTAGE_GROUP_WE;
	int miscompares;
	int comparisons;
	int unsigned seed;
	logic [7:0] v;
	logic [7:0] nv;
	logic seen;

	clock_guard dut (
		.CORE_CLK(CORE_CLK),
		.RESETN(RESETN),
		.ADDR(ADDR),
		.WDATA(WDATA),
		.WR(WR),
		.RD(RD),
		.RDATA(RDATA),
		.EXT_WRITE(EXT_WRITE),
		.WAIT_EXEC(WAIT_EXEC),
		.HW_INTERRUPT(HW_INTERRUPT),
		.MAIN_OSC_RUNNING(MAIN_OSC_RUNNING),
		.CLK_SEL(CLK_SEL),
		.OSC_EN(OSC_EN),
		.PWR_MODE(PWR_MODE),
		.PERIPH_STOP_IN_WAIT(PERIPH_STOP_IN_WAIT),
		.DETECT_IRQ(DETECT_IRQ),
		.OSC_STOP_RESET(OSC_STOP_RESET),
		.PORT_GROUP_WE(PORT_GROUP_WE),
		.VOLTAGE_GROUP_WE(VOLTAGE_GROUP_WE)
	);

	initial begin
		CORE_CLK = 1'b0;
		forever #50 CORE_CLK = ~CORE_CLK;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [4:0] exp_div(input logic d8, input logic hi,
		input logic lo);
		if (d8) begin
			return 5'h08;
		end
		case ({hi, lo})
			2'b00: return 5'h01;
			2'b01: return 5'h02;
			2'b10: return 5'h04;
			default: return 5'h10;
		endcase
	endfunction

	task automatic complete_run();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] e,
		input logic [7:0] got);
		comparisons++;
		if (got !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, e, got);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge CORE_CLK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge CORE_CLK);
		WR <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] m,
		input logic [7:0] e, input string n);
		@(posedge CORE_CLK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge CORE_CLK);
		RD <= 1'b0;
		#1;
		chk(n, e, RDATA & m);
	endtask

	// one-cycle event pulse: 0 outside write, 1 wait, 2 interrupt
	task automatic pulse(input int k);
		@(posedge CORE_CLK);
		case (k)
			0: EXT_WRITE <= 1'b1;
			1: WAIT_EXEC <= 1'b1;
			default: HW_INTERRUPT <= 1'b1;
		endcase
		@(posedge CORE_CLK);
		EXT_WRITE <= 1'b0;
		WAIT_EXEC <= 1'b0;
		HW_INTERRUPT <= 1'b0;
		#1;
	endtask

	task automatic osc(input logic run);
		@(posedge CORE_CLK);
		MAIN_OSC_RUNNING <= run;
	endtask

	// bounded watch; a missing pulse ends the run
	task automatic watch_irq(input logic e, input string n);
		seen = 1'b0;
		repeat (12) begin
			@(posedge CORE_CLK);
			#1;
			if (DETECT_IRQ === 1'b1) begin
				seen = 1'b1;
			end
		end
		chk(n, {7'h00, e}, {7'h00, seen});
		if (e && !seen) begin
			complete_run();
		end
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		miscompares = 0;
		comparisons = 0;
		RESETN = 1'b0;
		ADDR = 4'h0;
		WDATA = 8'h00;
		WR = 1'b0;
		RD = 1'b0;
		EXT_WRITE = 1'b0;
		WAIT_EXEC = 1'b0;
		HW_INTERRUPT = 1'b0;
		MAIN_OSC_RUNNING = 1'b1;
		seed = $urandom(57);
		repeat (8) @(posedge CORE_CLK);
		RESETN <= 1'b1;
		#1;
		chk("cpu_div", 8'h08, {3'h0, CLK_SEL.cpu_div});
		chk("cpu_src", 8'(SRC_MAIN), 8'(CLK_SEL.cpu_src));
		chk("osc_en", 8'h08, 8'(OSC_EN));
		chk("pwr_mode", 8'(PWR_RUN), 8'(PWR_MODE));
		rd(OFS_CLOCK_CTRL0, 8'hFF, RST_CLOCK_CTRL0, "ctrl0");
		rd(OFS_CLOCK_CTRL2, 8'hFF, 8'h00, "ctrl2");
		// writes without protection and to an unmapped place
		wr(OFS_CLOCK_CTRL1, 8'hC0);
		rd(OFS_CLOCK_CTRL1, 8'hFF, 8'h00, "ctrl1 guarded");
		wr(4'hF, 8'hFF);
		rd(4'hF, 8'hFF, 8'h00, "unmapped");
		// protect groups
		wr(OFS_WRITE_PROTECT, 8'h0F);
		chk("port_we", 8'h01, {7'h00, PORT_GROUP_WE});
		chk("volt_we", 8'h01, {7'h00, VOLTAGE_GROUP_WE});
		pulse(0);
		chk("port_we", 8'h00, {7'h00, PORT_GROUP_WE});
		chk("volt_we", 8'h01, {7'h00, VOLTAGE_GROUP_WE});
		rd(OFS_WRITE_PROTECT, 8'h0F, 8'h0B, "protect");
		wr(OFS_WRITE_PROTECT, 8'h0F);
		wr(4'hF, 8'h00);
		chk("port_we", 8'h00, {7'h00, PORT_GROUP_WE});
		wr(OFS_WRITE_PROTECT, 8'h01);
		chk("volt_we", 8'h00, {7'h00, VOLTAGE_GROUP_WE});
		// divider: all four codes, then eight random codes with div8 set at random
		for (int i = 0; i < 12; i++) begin
			v = 8'($urandom);
			if (i < 4) begin
				v = {i[1:0], 6'h00};
			end
			wr(OFS_CLOCK_CTRL0, {1'b0, v[0], 6'h00});
			wr(OFS_CLOCK_CTRL1, {v[7:6], 6'h00});
			chk("cpu_div", {3'h0, exp_div(v[0], v[7], v[6])},
				{3'h0, CLK_SEL.cpu_div});
		end
		// sources and oscillator enables
		wr(OFS_CLOCK_CTRL0, 8'h80);
		chk("cpu_src", 8'(SRC_SUB), 8'(CLK_SEL.cpu_src));
		wr(OFS_CLOCK_CTRL0, 8'h34);
		chk("main_en", 8'h00, {7'h00, OSC_EN.main_en});
		chk("stop_in_wait", 8'h01, {7'h00, PERIPH_STOP_IN_WAIT});
		chk("sub_en", 8'h01, {7'h00, OSC_EN.sub_en});
		wr(OFS_CLOCK_CTRL0, 8'h00);
		wr(OFS_CLOCK_CTRL2, 8'h02);
		chk("cpu_src", 8'(SRC_RING), 8'(CLK_SEL.cpu_src));
		wr(OFS_CLOCK_CTRL2, 8'h00);
		chk("cpu_src", 8'(SRC_MAIN), 8'(CLK_SEL.cpu_src));
		// clock lock
		wr(OFS_WRITE_PROTECT, 8'h03);
		wr(OFS_PROC_MODE2, 8'h02);
		wr(OFS_WRITE_PROTECT, 8'h01);
		wr(OFS_PROC_MODE2, 8'h00);
		rd(OFS_PROC_MODE2, 8'hFF, 8'h02, "pm2 guarded");
		nv = 8'($urandom);
		wr(OFS_CLOCK_CTRL0, nv);
		rd(OFS_CLOCK_CTRL0, 8'hF4, nv & ~LOCK_MASK_CTRL0 & 8'hF4,
			"ctrl0 lock");
		wr(OFS_PLL_CTRL, 8'hFF);
		rd(OFS_PLL_CTRL, 8'hFF, 8'h00, "pll lock");
		wr(OFS_CLOCK_CTRL2, 8'h01);
		rd(OFS_CLOCK_CTRL2, 8'h01, 8'h00, "ctrl2 lock");
		wr(OFS_WRITE_PROTECT, 8'h03);
		wr(OFS_PROC_MODE2, 8'h00);
		wr(OFS_PLL_CTRL, 8'h80);
		rd(OFS_PLL_CTRL, 8'hFF, 8'h80, "pll unlocked");
		wr(OFS_CLOCK_CTRL0, 8'h00);
		wr(OFS_WRITE_PROTECT, 8'h01);
		// power modes
		pulse(1);
		chk("pwr_mode", 8'(PWR_WAIT), 8'(PWR_MODE));
		pulse(2);
		chk("pwr_mode", 8'(PWR_RUN), 8'(PWR_MODE));
		wr(OFS_CLOCK_CTRL1, 8'h01);
		chk("pwr_mode", 8'(PWR_STOP), 8'(PWR_MODE));
		chk("osc_en", 8'h00, 8'(OSC_EN));
		pulse(2);
		chk("pwr_mode", 8'(PWR_RUN), 8'(PWR_MODE));
		rd(OFS_CLOCK_CTRL1, 8'h01, 8'h00, "stop bit");
		// detection with interrupt action
		wr(OFS_CLOCK_CTRL2, 8'h81);
		osc(1'b0);
		watch_irq(1'b1, "stop irq");
		rd(OFS_CLOCK_CTRL2, 8'hFF, 8'h8F, "ctrl2 stop");
		chk("cpu_src", 8'(SRC_RING), 8'(CLK_SEL.cpu_src));
		chk("periph_src", 8'(SRC_RING), 8'(CLK_SEL.periph_src));
		osc(1'b1);
		watch_irq(1'b0, "blocked irq");
		osc(1'b0);
		watch_irq(1'b0, "blocked irq");
		wr(OFS_CLOCK_CTRL2, 8'h83);
		rd(OFS_CLOCK_CTRL2, 8'h04, 8'h00, "flag cleared");
		osc(1'b1);
		watch_irq(1'b1, "restart irq");
		rd(OFS_CLOCK_CTRL2, 8'hFF, 8'h87, "ctrl2 restart");
		// detection on pll and sub clock sources
		wr(OFS_CLOCK_CTRL1, 8'h02);
		wr(OFS_CLOCK_CTRL2, 8'h81);
		osc(1'b0);
		watch_irq(1'b1, "pll stop irq");
		rd(OFS_CLOCK_CTRL2, 8'hFF, 8'h8D, "ctrl2 pll stop");
		chk("cpu_src", 8'(SRC_PLL), 8'(CLK_SEL.cpu_src));
		chk("periph_src", 8'(SRC_MAIN), 8'(CLK_SEL.periph_src));
		osc(1'b1);
		watch_irq(1'b0, "blocked irq");
		wr(OFS_CLOCK_CTRL1, 8'h00);
		wr(OFS_CLOCK_CTRL0, 8'h90);
		wr(OFS_CLOCK_CTRL2, 8'h81);
		osc(1'b0);
		watch_irq(1'b1, "sub stop irq");
		chk("cpu_src", 8'(SRC_SUB), 8'(CLK_SEL.cpu_src));
		chk("periph_src", 8'(SRC_RING), 8'(CLK_SEL.periph_src));
		chk("ring_en", 8'h01, {7'h00, OSC_EN.ring_en});
		osc(1'b1);
		watch_irq(1'b0, "blocked irq");
		// detection with reset action
		wr(OFS_CLOCK_CTRL2, 8'h01);
		osc(1'b0);
		watch_irq(1'b0, "no irq on reset");
		chk("stop_reset", 8'h01, {7'h00, OSC_STOP_RESET});
		@(posedge CORE_CLK);
		MAIN_OSC_RUNNING <= 1'b1;
		RESETN <= 1'b0;
		#1;
		chk("stop_reset", 8'h00, {7'h00, OSC_STOP_RESET});
		repeat (2) @(posedge CORE_CLK);
		RESETN <= 1'b1;
		repeat (2) @(posedge CORE_CLK);
		complete_run();
	end
endmodule
